// ### logic/bcx_pkg.sv
// Constants for the bit clear / bit test skip execution block.
// Assumes a single 50 MHz core clock with a four-phase instruction cycle.
// Notes on behaviour
// - Opcode 01 00bb bfff ffff clears bit b of file f, others kept.
// - Opcode 01 10bb bfff ffff tests bit; a one lets next instruction run.
// - Tested bit zero discards fetched next instruction, runs a no-op instead.
// - Skipping test takes two instruction cycles, non-skipping test takes one.
package bcx_pkg;
  localparam int          OPC_W        = 14;
  localparam int          ADDR_W       = 7;
  localparam int          DATA_W       = 8;
  localparam int          FILE_DEPTH   = 128;
  localparam int          CLK_MHZ      = 50;
  localparam logic [3:0]  OPC_CLR_PAT  = 4'h4;
  localparam logic [3:0]  OPC_TST_PAT  = 4'h6;
  localparam int          OPC_TOP_LSB  = 10;
  localparam int          BIT_LSB      = 7;
  localparam logic [3:0]  PHASE_RST    = 4'h1;
  localparam logic [7:0]  FILE_RST     = 8'h00;
  typedef enum logic [3:0]
  {
    PH_DECODE  = 4'h1,
    PH_READ    = 4'h2,
    PH_PROCESS = 4'h4,
    PH_WRITE   = 4'h8
  } bcx_phase_t;
endpackage

// ### logic/bcx_file_mem.sv
// File register store with one read and one write port.
// Assumes a single clock; read data come from a register; power-up content all ones.
`timescale 1ns/100ps
module bcx_file_mem #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
)(
  input  wire logic              clk_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic      [DATA_W-1:0] rd_data_out,
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in
);
  logic [DATA_W-1:0] mem_q [2**ADDR_W] = '{default: '1};

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end
endmodule

// ### logic/bcx_exec.sv
// Execution of the bit clear and bit test skip-if-zero instructions.
// Assumes the fetched opcode is held stable on OPC_IN for a whole cycle.
`timescale 1ns/100ps
module bcx_exec #(
  parameter int ADDR_W = bcx_pkg::ADDR_W,
  parameter int DATA_W = bcx_pkg::DATA_W
)(
  input  wire logic                      MCLK_IN,
  input  wire logic                      RSTN_IN,
  input  wire logic [bcx_pkg::OPC_W-1:0] OPC_IN,
  output logic      [3:0]                PHASE_OUT,
  output logic                           CYCLE_END_OUT,
  output logic                           SKIP_OUT,
  output logic                           NOP_CYCLE_OUT,
  output logic                           WR_EN_OUT,
  output logic      [ADDR_W-1:0]         WR_ADDR_OUT,
  output logic      [DATA_W-1:0]         WR_DATA_OUT
);
  if (ADDR_W != bcx_pkg::ADDR_W || DATA_W != bcx_pkg::DATA_W)
  begin : g_width_chk
    $error("bcx_exec supports 7-bit address and 8-bit data only");
  end

  bcx_pkg::bcx_phase_t phase_q;
  bcx_pkg::bcx_phase_t phase_d;
  logic [bcx_pkg::OPC_W-1:0] ir_q;
  logic                      nop_q;
  logic                      nop_d;
  logic [DATA_W-1:0]         rd_data;
  logic [DATA_W-1:0]         work_q;
  logic                      skip_q;
  logic                      wr_en_q;
  logic [ADDR_W-1:0]         wr_addr_q;
  logic [DATA_W-1:0]         wr_data_q;

  // Opcode fields
  wire [3:0]        opc_top  = ir_q[bcx_pkg::OPC_W-1:bcx_pkg::OPC_TOP_LSB];
  wire [2:0]        bit_sel  = ir_q[bcx_pkg::BIT_LSB+2:bcx_pkg::BIT_LSB];
  wire [ADDR_W-1:0] file_adr = ir_q[ADDR_W-1:0];
  // New opcode's file read during decode, data ready in read phase
  wire [ADDR_W-1:0] rd_adr   = (phase_q == bcx_pkg::PH_DECODE) ?
                               OPC_IN[ADDR_W-1:0] : file_adr;
  wire              is_clr   = !nop_q && opc_top == bcx_pkg::OPC_CLR_PAT;
  wire              is_tst   = !nop_q && opc_top == bcx_pkg::OPC_TST_PAT;
  wire [DATA_W-1:0] clr_mask = ~(DATA_W'(1) << bit_sel);
  wire              tst_bit  = work_q[bit_sel];
  wire              take_skip = is_tst && !tst_bit;
  wire              ph_end   = phase_q == bcx_pkg::PH_WRITE;

  // Phase ring
  always_comb
  begin
    case (phase_q)
      bcx_pkg::PH_DECODE:  phase_d = bcx_pkg::PH_READ;
      bcx_pkg::PH_READ:    phase_d = bcx_pkg::PH_PROCESS;
      bcx_pkg::PH_PROCESS: phase_d = bcx_pkg::PH_WRITE;
      bcx_pkg::PH_WRITE:   phase_d = bcx_pkg::PH_DECODE;
      default:             phase_d = bcx_pkg::PH_DECODE;
    endcase
  end

  // Next cycle is a no-op when the test skips
  assign nop_d = ph_end ? take_skip : nop_q;

  bcx_file_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_mem (
    .clk_in      (MCLK_IN),
    .rd_addr_in  (rd_adr),
    .rd_data_out (rd_data),
    .wr_en_in    (wr_en_q),
    .wr_addr_in  (wr_addr_q),
    .wr_data_in  (wr_data_q)
  );

  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      phase_q <= bcx_pkg::PH_DECODE;
      nop_q   <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      nop_q   <= nop_d;
    end
  end

  // Latch opcode in decode phase
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      ir_q <= '0;
    else if (phase_q == bcx_pkg::PH_DECODE)
      ir_q <= OPC_IN;
  end

  // File read data arrive in the process phase
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      work_q <= bcx_pkg::FILE_RST;
    else if (phase_q == bcx_pkg::PH_READ)
      work_q <= rd_data;
  end

  // Clear writes back in the write phase
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      wr_en_q   <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end
    else
    begin
      wr_en_q   <= phase_q == bcx_pkg::PH_PROCESS && is_clr;
      wr_addr_q <= file_adr;
      wr_data_q <= work_q & clr_mask;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      skip_q <= 1'b0;
    else if (ph_end)
      skip_q <= take_skip;
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      PHASE_OUT     <= bcx_pkg::PHASE_RST;
      CYCLE_END_OUT <= 1'b0;
      SKIP_OUT      <= 1'b0;
      NOP_CYCLE_OUT <= 1'b0;
      WR_EN_OUT     <= 1'b0;
      WR_ADDR_OUT   <= '0;
      WR_DATA_OUT   <= '0;
    end
    else
    begin
      PHASE_OUT     <= phase_q;
      CYCLE_END_OUT <= ph_end;
      SKIP_OUT      <= skip_q;
      NOP_CYCLE_OUT <= nop_q;
      WR_EN_OUT     <= wr_en_q;
      WR_ADDR_OUT   <= wr_addr_q;
      WR_DATA_OUT   <= wr_data_q;
    end
  end

  // Checks of phase order, file access, writes and skips
  phase_ring_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    phase_q == bcx_pkg::PH_DECODE |=> phase_q == bcx_pkg::PH_READ ##1
    phase_q == bcx_pkg::PH_PROCESS ##1 phase_q == bcx_pkg::PH_WRITE)
    else $error("phase sequence broken");

  read_addr_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    phase_q == bcx_pkg::PH_READ |-> $past(rd_adr) == file_adr)
    else $error("file read from stale address");

  clear_write_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    phase_q == bcx_pkg::PH_PROCESS && is_clr |=> wr_en_q &&
    phase_q == bcx_pkg::PH_WRITE && wr_data_q[bit_sel] == 1'b0)
    else $error("bit clear write missing");

  clear_keep_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    phase_q == bcx_pkg::PH_PROCESS && is_clr |=>
    (wr_data_q | ~clr_mask) == ($past(work_q) | ~clr_mask))
    else $error("bit clear disturbed other bits");

  write_only_clr_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    wr_en_q |-> phase_q == bcx_pkg::PH_WRITE && $past(is_clr))
    else $error("write outside clear write phase");

  clear_once_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    wr_en_q |=> !wr_en_q)
    else $error("clear wrote twice in one cycle");

  clear_no_skip_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    ph_end && is_clr |=> !nop_q)
    else $error("bit clear took a second cycle");

  out_write_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    wr_en_q |=> WR_EN_OUT && WR_ADDR_OUT == $past(wr_addr_q) &&
    WR_DATA_OUT == $past(wr_data_q))
    else $error("write outputs do not follow write");

  test_no_write_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    phase_q == bcx_pkg::PH_PROCESS && is_tst |=> !wr_en_q)
    else $error("bit test wrote a file");

  test_noskip_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    ph_end && is_tst && tst_bit |=> !nop_q)
    else $error("test with bit set skipped");

  test_skip_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    ph_end && take_skip |=> nop_q [*4] ##1 !nop_q)
    else $error("skip not exactly one no-op cycle");

  nop_align_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    $rose(nop_q) |-> phase_q == bcx_pkg::PH_DECODE)
    else $error("no-op cycle not aligned");

  nop_no_write_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    nop_q |-> !wr_en_q && !is_tst && !is_clr)
    else $error("discarded instruction acted");

  skip_flag_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    ph_end |=> skip_q == nop_q)
    else $error("skip flag mismatch");
endmodule

// ### bench/bcx_exec_tb.sv
// Self-checking bench for the bit clear / bit test skip block.
// Assumes the package and the block's own assertions are compiled first.
`timescale 1ns/100ps
module bcx_exec_tb;
  logic        mclk     = 1'b0;
  logic        rstn     = 1'b0;
  logic [13:0] opc      = 14'h0000;
  logic [3:0]  phase;
  logic        cyc_end;
  logic        skip;
  logic        nop;
  logic        wr_en;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        w0_en;
  logic [6:0]  w0_addr;
  logic [7:0]  w0_data;
  int          errors   = 0;
  int          checks   = 0;
  int          skip_cnt = 0;
  int          wr_cnt   = 0;

  always #10 mclk = ~mclk;

  bcx_exec bcx_exec_i (.MCLK_IN(mclk), .RSTN_IN(rstn), .OPC_IN(opc), .PHASE_OUT(phase),
    .CYCLE_END_OUT(cyc_end), .SKIP_OUT(skip), .NOP_CYCLE_OUT(nop), .WR_EN_OUT(wr_en),
    .WR_ADDR_OUT(wr_addr), .WR_DATA_OUT(wr_data));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [13:0] clr(input logic [2:0] b, input logic [6:0] f);
    return {2'b01, 2'b00, b, f};
  endfunction

  function automatic logic [13:0] tst(input logic [2:0] b, input logic [6:0] f);
    return {2'b01, 2'b10, b, f};
  endfunction

  // One instruction cycle; last sample shows this cycle's write
  task automatic step(input logic [13:0] op);
    opc = op;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk);
      @(negedge mclk);
      if (k == 3)
      begin
        w0_en   = wr_en;
        w0_addr = wr_addr;
        w0_data = wr_data;
      end
      if (wr_en === 1'b1) wr_cnt++;
      if (skip === 1'b1) skip_cnt++;
      check("phase", {4'h0, phase}, 8'(1 << k));
      check("nop flag", {7'h00, nop}, {7'h00, skip});
      check("cycle end", {7'h00, cyc_end}, {7'h00, k == 3});
    end
  endtask

  task automatic reset_chk();
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check("phase in reset", {4'h0, phase}, 8'h01);
    check("wr in reset", {7'h00, wr_en}, 8'h00);
    check("skip in reset", {7'h00, skip}, 8'h00);
    rstn = 1'b1;
  endtask

  // Clears bits 0..7 of file 127 back to back, then bit 0 of file 0
  task automatic clear_seq();
    for (int b = 0; b < 9; b++)
    begin
      step(b < 8 ? clr(3'(b), 7'h7f) : clr(3'h0, 7'h00));
      check("clr wr_en", {7'h00, w0_en}, 8'h01);
      check("clr addr", {1'b0, w0_addr}, b < 8 ? 8'h7f : 8'h00);
      check("clr data", w0_data, b < 8 ? 8'(8'hfe << b) : 8'hfe);
    end
  endtask

  // Set bit runs the next clear; clear bit discards it for one cycle
  task automatic skip_seq();
    skip_cnt = 0;
    wr_cnt   = 0;
    step(tst(3'h2, 7'h05));
    step(clr(3'h2, 7'h05));
    check("noskip cycles", 8'(skip_cnt), 8'h00);
    check("noskip wr", {w0_en, w0_addr}, 8'h85);
    check("noskip data", w0_data, 8'hfb);
    wr_cnt = 0;
    step(tst(3'h2, 7'h05));
    step(clr(3'h4, 7'h05));
    check("skip cycles", 8'(skip_cnt), 8'h04);
    step(tst(3'h4, 7'h05));
    step(tst(3'h7, 7'h7f));
    step(clr(3'h3, 7'h05));
    step(tst(3'h0, 7'h00));
    step(clr(3'h1, 7'h05));
    step(14'h0000);
    check("skip cycles", 8'(skip_cnt), 8'h0c);
    check("discarded writes", 8'(wr_cnt), 8'h00);
    step(clr(3'h4, 7'h05));
    check("kept data", w0_data, 8'heb);
  endtask

  // Reset inside a no-op cycle drops the skip; files keep their content
  task automatic reset_mid();
    skip_cnt = 0;
    step(tst(3'h7, 7'h7f));
    opc = clr(3'h5, 7'h05);
    @(posedge mclk);
    @(negedge mclk);
    check("skip before reset", {6'h00, skip, nop}, 8'h03);
    rstn = 1'b0;
    @(negedge mclk);
    check("skip in mid reset", {6'h00, skip, nop}, 8'h00);
    check("phase in mid reset", {4'h0, phase}, 8'h01);
    rstn = 1'b1;
    step(tst(3'h5, 7'h05));
    step(clr(3'h5, 7'h05));
    check("after reset skips", 8'(skip_cnt), 8'h00);
    check("after reset data", w0_data, 8'hcb);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    reset_chk();
    clear_seq();
    skip_seq();
    reset_mid();
    final_report();
  end
endmodule
